// >>> npi_pkg.sv
// Contract
// R1 - byte bus carries commands, addresses, data
// R2 - memory floats bus when deselected
// R3 - address strobe high captures address byte
// R4 - command strobe high captures command byte
// R5 - no strobe means data byte captured
// R6 - die pair active only while select low
// R7 - busy pair stays selected after select rises
// R8 - each read strobe fall gives next byte
// R9 - read strobe fall advances column by one
// R10 - host waits 10 us recovery before commands
// R11 - host keeps write strobe high during recovery
// R12 - lock low rejects program and erase
// R13 - host holds lock low in power transitions
// R14 - busy line low while operation runs
// R15 - shared busy low means someone busy
// R16 - memory holds busy low during recovery
// R17 - below lockout threshold everything disabled
// R18 - die pairs independent, own select and busy
// R19 - never both latch strobes in one cycle
package npi_pkg;
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned RECOVERY_NS    = 10000;   // 10 us minimum
  localparam int unsigned RECOVERY_CYC   =
    (RECOVERY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned STROBE_LOW_CYC  = 2;      // strobe low phase
  localparam int unsigned STROBE_HIGH_CYC = 2;      // strobe high phase
  localparam int unsigned FIFO_DEPTH     = 8;
  localparam int unsigned BYTE_W         = 8;

  typedef enum logic [1:0] {
    NPI_KIND_CMD  = 2'h0,
    NPI_KIND_ADDR = 2'h1,
    NPI_KIND_DATA = 2'h2,
    NPI_KIND_READ = 2'h3
  } npi_kind_t;

  typedef enum logic [2:0] {
    NPI_ST_RECOVER = 3'h0,
    NPI_ST_IDLE    = 3'h1,
    NPI_ST_LOW     = 3'h2,
    NPI_ST_HIGH    = 3'h3,
    NPI_ST_PUSH    = 3'h4
  } npi_state_t;
endpackage

// >>> npi_fifo.sv
`timescale 1ns/100ps
module npi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,      // system clock
  input  wire logic             rst,      // sync reset, high
  input  wire logic [WIDTH-1:0] inData,   // write data
  input  wire logic             inValid,  // write request
  output logic                  inReady,  // not full
  output logic      [WIDTH-1:0] outData,  // head word
  output logic                  outValid, // not empty
  input  wire logic             outReady  // drain accepts head
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  wire              doWr = inValid && inReady;
  wire              doRd = outValid && outReady;

  // honest flags from the occupancy count
  assign inReady  = (count_q < (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];

  // storage has no reset; only pointers matter
  always_ff @(posedge clk)
  begin
    if (doWr)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (doWr) wrPtr_q <= wrPtr_q + 1'b1;
      if (doRd) rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule // npi_fifo

// >>> npi_host.sv
`timescale 1ns/100ps
module npi_host (
  input  wire logic        clk,                    // 20 MHz system clock
  input  wire logic        rst,                    // sync reset, high
  // request side: one bus cycle per request
  input  wire logic        reqValid,               // request offered
  output logic             reqReady,               // high the cycle after a request is taken
  input  wire logic [1:0]  reqKind,                // npi_kind_t
  input  wire logic        reqPair,                // 0 pair a, 1 pair b
  input  wire logic [7:0]  reqByte,                // command, address or data
  input  wire logic        lockRelease,            // 1 allows program/erase
  // read data side through the fifo
  output logic [7:0]       rdData,                 // read byte
  output logic             rdValid,                // read byte present
  input  wire logic        rdReady,                // consumer takes byte
  // status
  output logic             recovering,             // power recovery running
  output logic             busyA,                  // pair a busy
  output logic             busyB,                  // pair b busy
  // pins
  input  wire logic [7:0]  shared_byte_bus_i,      // bus level in
  output logic [7:0]       shared_byte_bus_o,      // bus drive value
  output logic             shared_byte_bus_oe,     // high while host drives
  output logic             address_latch_strobe,   // address latch strobe
  output logic             command_latch_strobe,   // command latch strobe
  output logic             die_pair_select_a_n,    // pair a select, low active
  output logic             die_pair_select_b_n,    // pair b select, low active
  output logic             read_strobe_n,          // read strobe, low active
  output logic             write_strobe_n,         // write strobe, low active
  output logic             pe_lock_n,              // low locks program/erase
  input  wire logic        busy_line_a_i,          // busy a, low busy
  input  wire logic        busy_line_b_i           // busy b, low busy
);
  localparam int unsigned CW = $clog2(npi_pkg::RECOVERY_CYC + 1);

  npi_pkg::npi_state_t state_q;
  npi_pkg::npi_state_t state_d;
  logic [CW-1:0]       cnt_q;
  logic [CW-1:0]       cnt_d;
  logic [1:0]          kind_q;
  logic                pair_q;
  logic [7:0]          byte_q;
  logic [7:0]          capt_q;
  logic [7:0]          busSync1_q;
  logic [7:0]          busSync2_q;
  logic [1:0]          busySync1_q;
  logic [1:0]          busySync2_q;

  // fifo ready, valid and head data
  logic                fifoInReady;
  logic                fifoOutValid;
  logic [7:0]          fifoOutData;

  // decode of current transfer
  wire isRead   = (kind_q == npi_pkg::NPI_KIND_READ);
  wire cntDone  = (cnt_q == '0);
  wire take     = (state_q == npi_pkg::NPI_ST_IDLE) && reqValid;
  wire pushByte = (state_q == npi_pkg::NPI_ST_PUSH) && fifoInReady;

  // next-cycle view of the transfer so pins move with the state
  wire       activeD = (state_d == npi_pkg::NPI_ST_LOW) || (state_d == npi_pkg::NPI_ST_HIGH);
  wire [1:0] kindD   = take ? reqKind : kind_q;
  wire       pairD   = take ? reqPair : pair_q;
  wire [7:0] byteD   = take ? reqByte : byte_q;
  wire       isReadD = (kindD == npi_pkg::NPI_KIND_READ);
  wire       wrLowD  = (state_d == npi_pkg::NPI_ST_LOW) && !isReadD;
  wire       rdLowD  = (state_d == npi_pkg::NPI_ST_LOW) && isReadD;

  // synced bus lags the pin by two edges, so the byte is taken in the
  // first high-phase cycle; the strobe rise only reaches it one edge later
  wire captNow = (state_q == npi_pkg::NPI_ST_HIGH)
    && (cnt_q == CW'(npi_pkg::STROBE_HIGH_CYC - 1));

  // output stage refills whenever it is empty or being drained
  wire outAdvance = !rdValid || rdReady;

  // both pins synced before use, bus only sampled after second flop
  always_ff @(posedge clk)
  begin
    busSync1_q  <= shared_byte_bus_i;
    busSync2_q  <= busSync1_q;
    busySync1_q <= {busy_line_b_i, busy_line_a_i};
    busySync2_q <= busySync1_q;
  end

  // sequencer: recovery, then low and high phases of one strobe
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cntDone ? cnt_q : cnt_q - 1'b1;
    case (state_q)
      npi_pkg::NPI_ST_RECOVER:
        if (cntDone) state_d = npi_pkg::NPI_ST_IDLE;                      // R10
      npi_pkg::NPI_ST_IDLE:
        if (reqValid)
        begin
          state_d = npi_pkg::NPI_ST_LOW;
          cnt_d   = CW'(npi_pkg::STROBE_LOW_CYC - 1);
        end
      npi_pkg::NPI_ST_LOW:
        if (cntDone)
        begin
          state_d = npi_pkg::NPI_ST_HIGH;
          cnt_d   = CW'(npi_pkg::STROBE_HIGH_CYC - 1);
        end
      npi_pkg::NPI_ST_HIGH:
        if (cntDone) state_d = isRead ? npi_pkg::NPI_ST_PUSH : npi_pkg::NPI_ST_IDLE;
      npi_pkg::NPI_ST_PUSH:
        if (fifoInReady) state_d = npi_pkg::NPI_ST_IDLE;   // stalls while fifo full
      default:
        state_d = npi_pkg::NPI_ST_IDLE;
    endcase
  end

  // state and phase counter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= npi_pkg::NPI_ST_RECOVER;
      cnt_q   <= CW'(npi_pkg::RECOVERY_CYC - 1);
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // request capture; kind and pair hold for the whole transfer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      kind_q <= npi_pkg::NPI_KIND_CMD;
      pair_q <= 1'b0;
      byte_q <= 8'h00;
    end
    else if (take)
    begin
      kind_q <= reqKind;
      pair_q <= reqPair;
      byte_q <= reqByte;
    end
  end

  // read byte taken once the synced copy holds it
  always_ff @(posedge clk)
  begin
    if (rst) capt_q <= 8'h00;
    else if (captNow && isRead)
      capt_q <= busSync2_q;                                               // R8
  end

  // pin drivers, all registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      write_strobe_n       <= 1'b1;                                       // R11
      read_strobe_n        <= 1'b1;
      address_latch_strobe <= 1'b0;
      command_latch_strobe <= 1'b0;
      die_pair_select_a_n  <= 1'b1;
      die_pair_select_b_n  <= 1'b1;
      shared_byte_bus_o    <= 8'h00;
      shared_byte_bus_oe   <= 1'b0;
      pe_lock_n            <= 1'b0;                                       // R13
      reqReady             <= 1'b0;
      recovering           <= 1'b1;
      busyA                <= 1'b1;
      busyB                <= 1'b1;
    end
    else
    begin
      // strobe low only in low phase; selects held across the transfer
      write_strobe_n       <= !wrLowD;                                       // R5
      read_strobe_n        <= !rdLowD;                                       // R9
      address_latch_strobe <= activeD && kindD == npi_pkg::NPI_KIND_ADDR;    // R3
      command_latch_strobe <= activeD && kindD == npi_pkg::NPI_KIND_CMD;     // R4 R19
      die_pair_select_a_n  <= !(activeD && !pairD);                          // R6 R18
      die_pair_select_b_n  <= !(activeD && pairD);                           // R18
      shared_byte_bus_o    <= byteD;                                         // R1
      shared_byte_bus_oe   <= activeD && !isReadD;                           // R2
      pe_lock_n            <= (state_q != npi_pkg::NPI_ST_RECOVER) && lockRelease; // R12
      reqReady             <= take;
      recovering           <= (state_d == npi_pkg::NPI_ST_RECOVER);          // R16
      busyA                <= !busySync2_q[0];                               // R14 R15
      busyB                <= !busySync2_q[1];                               // R15 R17
    end
  end

  // read buffer; a stalled consumer blocks further reads
  npi_fifo #(
    .WIDTH (npi_pkg::BYTE_W),
    .DEPTH (npi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (capt_q),
    .inValid  (pushByte),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (outAdvance)
  );

  // registered read outputs; adds one word of buffering past the fifo
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdValid <= 1'b0;
      rdData  <= 8'h00;
    end
    else if (outAdvance)
    begin
      rdValid <= fifoOutValid;
      rdData  <= fifoOutData;
    end
  end
endmodule // npi_host

// >>> npi_checker.sv
`timescale 1ns/100ps
module npi_checker (
  input wire logic       clk,                  // clock
  input wire logic       rst,                  // sync reset
  input wire logic       reqReady,             // request taken
  input wire logic [1:0] reqKind,              // request kind
  input wire logic       recovering,           // recovery running
  input wire logic       address_latch_strobe, // address strobe
  input wire logic       command_latch_strobe, // command strobe
  input wire logic       write_strobe_n,       // write strobe
  input wire logic       read_strobe_n,        // read strobe
  input wire logic       shared_byte_bus_oe,   // host drives bus
  input wire logic       die_pair_select_a_n,  // select a
  input wire logic       die_pair_select_b_n,  // select b
  input wire logic       pe_lock_n,            // lock
  input wire logic       busyA,                // busy a flag
  input wire logic       busy_line_a_i         // busy a pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_quiet; recovering |-> write_strobe_n && die_pair_select_a_n
    && die_pair_select_b_n && !pe_lock_n; endproperty
  a_quiet: assert property (p_quiet) else $error("pins active in recovery");
  property p_wrDrive; !write_strobe_n |-> shared_byte_bus_oe
    && (die_pair_select_a_n != die_pair_select_b_n); endproperty
  a_wrDrive: assert property (p_wrDrive) else $error("write without bus");
  property p_rdFloat; !read_strobe_n |-> !shared_byte_bus_oe
    && (die_pair_select_a_n != die_pair_select_b_n); endproperty
  a_rdFloat: assert property (p_rdFloat) else $error("read with bus driven");
  property p_wrPulse; $fell(write_strobe_n) |-> ##1 !write_strobe_n ##1 write_strobe_n;
  endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write strobe width");
  property p_rdPulse; $fell(read_strobe_n) |-> ##1 !read_strobe_n ##1 read_strobe_n;
  endproperty
  a_rdPulse: assert property (p_rdPulse) else $error("read strobe width");
  property p_ready; reqReady |-> $fell(write_strobe_n) || $fell(read_strobe_n); endproperty
  a_ready: assert property (p_ready) else $error("ready without strobe");
  property p_latch; reqReady |-> command_latch_strobe == (reqKind == npi_pkg::NPI_KIND_CMD)
    && address_latch_strobe == (reqKind == npi_pkg::NPI_KIND_ADDR); endproperty
  a_latch: assert property (p_latch) else $error("latch strobe wrong");
  property p_noBoth; !(address_latch_strobe && command_latch_strobe); endproperty
  a_noBoth: assert property (p_noBoth) else $error("both latch strobes");
  property p_busy; $fell(busy_line_a_i) |-> ##[1:3] busyA; endproperty
  a_busy: assert property (p_busy) else $error("busy a not seen");
endmodule // npi_checker
bind npi_host npi_checker npi_checker_i (.*);

// >>> npi_mem_model.sv
`timescale 1ns/100ps
module npi_mem_model #(
  parameter int unsigned BUSY_NS = 3000 // plain operation time
) (
  input wire logic [7:0] busIn,                // bus level
  output logic     [7:0] busOut,               // read byte, or float pattern
  input wire logic       address_latch_strobe, // address strobe
  input wire logic       command_latch_strobe, // command strobe
  input wire logic       die_pair_select_a_n,  // select a
  input wire logic       die_pair_select_b_n,  // select b
  input wire logic       read_strobe_n,        // read strobe
  input wire logic       write_strobe_n,       // write strobe
  input wire logic       pe_lock_n,            // lock
  output logic     [1:0] busyN                 // open drain busy, pulled up
);
  logic [7:0] mem [2][16];
  logic [3:0] col [2];
  logic       live; // low while supply is still coming up
  wire        pair = die_pair_select_a_n; // 0 pair a
  wire        sel  = !(die_pair_select_a_n && die_pair_select_b_n);
  // erased array, busy held low through recovery
  initial
  begin
    foreach (mem[p, c]) mem[p][c] = 8'hFF;
    col = '{4'h0, 4'h0};
    busOut = 8'h00;
    busyN = 2'h0;
    live = 1'b0;
    #10000 busyN = 2'h3;
    live = 1'b1;
  end
  // capture on strobe rise, kind set by latch strobes
  always @(posedge write_strobe_n)
    if (sel && live)
    begin
      if (command_latch_strobe)
        fork op(pair); join_none
      else if (address_latch_strobe)
        col[pair] = busIn[3:0];
      else if (pe_lock_n)
      begin
        mem[pair][col[pair]] = busIn;
        col[pair]++;
      end
    end
  // next byte on each fall; bus shows inverse once released, no pull-up
  always @(negedge read_strobe_n)
    if (sel && live)
    begin
      busOut = mem[pair][col[pair]];
      col[pair]++;
    end
  always @(posedge read_strobe_n) busOut = ~busOut;
  task automatic op(input logic p);
    busyN[p] = 1'b0;
    #(BUSY_NS) busyN[p] = 1'b1;
  endtask
endmodule // npi_mem_model

// >>> tb_npi_host.sv
`timescale 1ns/100ps
module tb_npi_host;
  logic clk = 0, rst = 1, reqValid = 0, reqPair = 0, lockRelease = 0, rdReady = 0;
  logic [1:0] reqKind = 2'h0, bz;
  logic [7:0] reqByte = 8'h00, rdData, hostO, memO;
  logic reqReady, rdValid, recovering, busyA, busyB, oe, ale, cle, selA, selB, rdN, wrN, lockN;
  int n_fail = 0, check_count = 0;
  wire [7:0] bus = oe ? hostO : memO;
  always #25 clk = ~clk;
  npi_host npi_host_i (.clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
    .reqKind(reqKind), .reqPair(reqPair), .reqByte(reqByte), .lockRelease(lockRelease),
    .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady), .recovering(recovering),
    .busyA(busyA), .busyB(busyB), .shared_byte_bus_i(bus), .shared_byte_bus_o(hostO),
    .shared_byte_bus_oe(oe), .address_latch_strobe(ale), .command_latch_strobe(cle),
    .die_pair_select_a_n(selA), .die_pair_select_b_n(selB), .read_strobe_n(rdN),
    .write_strobe_n(wrN), .pe_lock_n(lockN), .busy_line_a_i(bz[0]), .busy_line_b_i(bz[1]));
  npi_mem_model npi_mem_model_i (.busIn(bus), .busOut(memO), .address_latch_strobe(ale),
    .command_latch_strobe(cle), .die_pair_select_a_n(selA), .die_pair_select_b_n(selB),
    .read_strobe_n(rdN), .write_strobe_n(wrN), .pe_lock_n(lockN), .busyN(bz));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until taken; bounded wait
  task automatic req(input logic [1:0] k, input logic p, input logic [7:0] b, output bit ok);
    ok = 0;
    @(negedge clk);
    {reqKind, reqPair, reqByte, reqValid} = {k, p, b, 1'b1};
    repeat (100) if (!ok)
    begin
      @(posedge clk);
      #1 ok = (reqReady === 1'b1);
    end
    @(negedge clk);
    reqValid = 0;
  endtask
  task automatic wr(input logic [1:0] k, input logic p, input logic [7:0] b);
    bit ok;
    req(k, p, b, ok);
    chk("taken", 8'h01, {7'h0, ok});
  endtask
  task automatic pop(input logic [7:0] exp);
    int i;
    i = 0;
    @(negedge clk);
    while (rdValid !== 1'b1 && i < 60)
    begin
      @(negedge clk);
      i++;
    end
    chk("rdData", exp, rdData);
    rdReady = 1;
    @(negedge clk);
    rdReady = 0;
  endtask
  task automatic t_recover;
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(negedge clk) rst = 0;
    while (recovering === 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1 n++;
      if (n == 20) seen = busyA;
    end
    chk("recovery", 8'h01, {7'h0, n >= npi_pkg::RECOVERY_CYC});
    chk("busyRecover", 8'h01, {7'h0, seen});
  endtask
  // locked: data write must not land
  task automatic t_lock;
    wr(2'h1, 0, 8'h00);
    wr(2'h2, 0, 8'hEE);
    wr(2'h1, 0, 8'h00);
    wr(2'h3, 0, 8'h00);
    pop(8'hFF);
  endtask
  // fill fifo and output stage with reads, tenth is taken at once and its push waits for a drain
  task automatic t_fill;
    bit ok;
    lockRelease = 1;
    wr(2'h1, 1, 8'h00);
    for (int i = 0; i < 10; i++) wr(2'h2, 1, 8'h10 + i[7:0]);
    chk("lockN", 8'h01, {7'h0, lockN});
    wr(2'h1, 1, 8'h00);
    for (int i = 0; i < 9; i++) wr(2'h3, 1, 8'h00);
    fork
      req(2'h3, 1, 8'h00, ok);
      begin
        repeat (40) @(negedge clk);
        pop(8'h10);
      end
    join
    chk("tenth", 8'h01, {7'h0, ok});
    for (int i = 1; i < 10; i++) pop(8'h10 + i[7:0]);
  endtask
  // pair a busy, pair b still served
  task automatic t_busy;
    wr(2'h0, 0, 8'h60);
    repeat (8) @(negedge clk);
    chk("busyA", 8'h01, {7'h0, busyA});
    chk("busyB", 8'h00, {7'h0, busyB});
    wr(2'h0, 1, 8'h70);
    repeat (150) @(negedge clk);
    chk("busyDone", 8'h00, {7'h0, busyA});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    t_recover;
    t_lock;
    t_fill;
    t_busy;
    end_sim;
  end
  // watchdog well beyond the expected several hundred cycles
  initial
  begin
    #2000000 n_fail++;
    end_sim;
  end
endmodule // tb_npi_host
